/* hdl/lcd_cmd_pkg.sv */
// ****************************************
// constants and types of the command port
// ****************************************
package lcd_cmd_pkg;
   // instruction codes that pick the data register
   localparam logic [7:0] CODE_HCOUNT = 8'h02;
   localparam logic [7:0] CODE_DUTY = 8'h03;
   localparam logic [7:0] CODE_CROW = 8'h04;
   localparam logic [7:0] CODE_START_LO = 8'h08;
   localparam logic [7:0] CODE_START_HI = 8'h09;
   localparam logic [7:0] CODE_CUR_LO = 8'h0a;
   localparam logic [7:0] CODE_CUR_HI = 8'h0b;
   localparam logic [7:0] CODE_RAM_WR = 8'h0c;
   localparam logic [7:0] CODE_RAM_RD = 8'h0d;
   localparam logic [7:0] CODE_BIT_CLR = 8'h0e;
   localparam logic [7:0] CODE_BIT_SET = 8'h0f;
   // field layouts of the data bytes
   localparam int COUNT_MSB = 6;
   localparam int ROW_MSB = 3;
   localparam int BIT_IDX_MSB = 2;
   localparam int START_HI_KEEP_MSB = 3;
   localparam int BUSY_BIT = 7;
   localparam int ADDR_W = 16;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
   localparam logic [3:0] RESET_PITCH = 4'h8;
   // timing: clock period and execution times, all in ns
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_SET_NS = 4000;
   localparam int T_RAM_NS = 6000;
   localparam int T_BIT_NS = 36000;
   // longest times round down to whole cycles
   localparam int SET_CYCLES = T_SET_NS / CLK_PERIOD_NS;
   localparam int RAM_CYCLES = T_RAM_NS / CLK_PERIOD_NS;
   localparam int BIT_CYCLES = T_BIT_NS / CLK_PERIOD_NS;
   // cycles outside the wait count: pin sync, accept, pop, start, modify
   localparam int EXEC_OVERHEAD = 9;
   localparam int CNT_W = 10;
   localparam int FIFO_DEPTH = 8;
   // one queued operation
   typedef struct packed {
      logic is_read;
      logic [7:0] code;
      logic [7:0] data;
   } cmd_entry_s;
   // execution engine states
   typedef enum logic [1:0] {EX_IDLE, EX_START, EX_MODIFY, EX_WAIT} exec_state_e;
endpackage : lcd_cmd_pkg

/* hdl/display_ram.sv */
`timescale 1ns/1ps
// ****************************************
// display memory, one byte per address
// ****************************************
module display_ram (
   // clock
   input wire logic sys_clk,
   // access port
   input wire logic [15:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:65535]; // full 64k byte space, no reset on purpose

   // ****************************************
   // read first, registered read
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
   end
endmodule : display_ram

/* hdl/cmd_fifo.sv */
`timescale 1ns/1ps
// ****************************************
// small synchronous fifo, valid/ready both sides
// ****************************************
module cmd_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage
   logic [PW-1:0] wr_ptr; // next slot to fill
   logic [PW-1:0] rd_ptr; // next slot to drain
   logic [PW:0] count; // occupancy
   logic push;
   logic pop;

   assign in_ready = (count != (PW+1)'(DEPTH)); // honest full
   assign out_valid = (count != '0); // honest empty
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ****************************************
   // storage write
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // ****************************************
   // pointers and occupancy
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : cmd_fifo

/* hdl/lcd_command_port.sv */
`timescale 1ns/1ps
// Operation
// RL1 - select-high write loads instruction; data write executes
// RL2 - code 02 sets character count minus one
// RL3 - code 03 sets time divisions minus one
// RL4 - code 04 sets cursor row minus one
// RL5 - cursor length equals horizontal character pitch
// RL6 - codes 08/09 load display start address
// RL7 - character mode drops top four start bits
// RL8 - codes 0A/0B load cursor, low carries upward
// RL9 - host rewrites high cursor byte after low
// RL10 - code 0C writes RAM, cursor increments
// RL11 - code 0D returns latch, reloads, increments
// RL12 - host discards first read after cursor set
// RL13 - codes 0E/0F clear/set one bit, increment
// RL14 - select-high read returns busy on bit7
// RL15 - busy while executing; ignore new commands
// RL16 - host polls busy before instruction or data
// RL17 - register-setting commands finish within four microseconds
// RL18 - RAM access and cursor share cursor address
// RL19 - data write while busy is discarded
module lcd_command_port (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // host bus pins
   input wire logic strobe_pin,
   input wire logic rw_pin,
   input wire logic reg_select,
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic bus_oe,
   // mode settings from the mode control logic
   input wire logic graphic_mode,
   input wire logic [3:0] char_pitch,
   // settings toward the display timing logic
   output logic [6:0] horizontal_count,
   output logic [6:0] time_division_count,
   output logic [3:0] cursor_row,
   output logic [15:0] display_start,
   output logic [15:0] cursor_address,
   output logic [3:0] cursor_length,
   output logic busy_flag
);
   // ****************************************
   // declarations
   // ****************************************
   // three-stage pin synchronisers
   logic [10:0] pin_s1; // first stage, read only by pin_s2
   logic [10:0] pin_s2;
   logic [10:0] pin_s3;
   logic [10:0] pin_level; // accepted levels
   logic strobe_prev; // for edge detection
   logic strobe_fall; // end of a host strobe
   logic pin_rw;
   logic pin_rs;
   logic [7:0] pin_data;
   // command capture
   logic [7:0] instr_code; // selected data register
   logic [7:0] out_latch; // data output latch for RAM reads
   logic [7:0] start_low;
   logic [7:0] start_high;
   lcd_cmd_pkg::cmd_entry_s push_entry;
   logic push_valid;
   logic push_ready;
   lcd_cmd_pkg::cmd_entry_s pop_entry;
   logic pop_valid;
   logic pop_ready;
   // execution engine
   lcd_cmd_pkg::exec_state_e state;
   lcd_cmd_pkg::exec_state_e next_state;
   lcd_cmd_pkg::cmd_entry_s cur; // operation in progress
   logic [lcd_cmd_pkg::CNT_W-1:0] wait_cnt;
   logic ram_wr_en;
   logic [7:0] ram_wr_data;
   logic [7:0] ram_rd_data;
   logic data_accept;
   logic next_busy;

   // ****************************************
   // helper functions
   // ****************************************
   // one-hot mask of the addressed bit, index 0 is the lsb
   function automatic logic [7:0] bit_mask(input logic [7:0] data);
      bit_mask = 8'h01 << data[lcd_cmd_pkg::BIT_IDX_MSB:0];
   endfunction : bit_mask

   // wait count after the fixed overhead for a given code
   function automatic logic [lcd_cmd_pkg::CNT_W-1:0] exec_wait(input logic [7:0] code);
      int cyc;
      cyc = lcd_cmd_pkg::SET_CYCLES;
      case (code)
         lcd_cmd_pkg::CODE_RAM_WR,
         lcd_cmd_pkg::CODE_RAM_RD: begin
            cyc = lcd_cmd_pkg::RAM_CYCLES;
         end
         lcd_cmd_pkg::CODE_BIT_CLR,
         lcd_cmd_pkg::CODE_BIT_SET: begin
            cyc = lcd_cmd_pkg::BIT_CYCLES;
         end
         default: begin
            cyc = lcd_cmd_pkg::SET_CYCLES;
         end
      endcase
      exec_wait = lcd_cmd_pkg::CNT_W'(cyc - lcd_cmd_pkg::EXEC_OVERHEAD);
   endfunction : exec_wait

   // cursor increment, also used by the bit and RAM commands
   function automatic logic [15:0] cursor_next(input logic [15:0] addr);
      cursor_next = addr + 16'h0001;
   endfunction : cursor_next

   // ****************************************
   // pin synchronisers
   // ****************************************
   // a level changes only once stages two and three agree;
   // this costs four cycles of latency but rejects single-cycle glitches
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= {strobe_pin, rw_pin, reg_select, bus_in};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // agreed levels, bit by bit
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_level <= '0;
         strobe_prev <= 1'b0;
      end else begin
         for (int i = 0; i < 11; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin_level[i] <= pin_s3[i];
            end
         end
         strobe_prev <= pin_level[10];
      end
   end

   assign strobe_fall = strobe_prev && !pin_level[10];
   assign pin_rw = pin_level[9];
   assign pin_rs = pin_level[8];
   assign pin_data = pin_level[7:0];

   // ****************************************
   // host access decode
   // ****************************************
   // data accesses while busy are dropped outright, not queued
   assign data_accept = strobe_fall && !pin_rs && !busy_flag && push_ready // see RL19
                        && (!pin_rw || instr_code == lcd_cmd_pkg::CODE_RAM_RD);
   assign push_valid = data_accept; // see RL1
   assign push_entry = '{is_read: pin_rw, code: instr_code, data: pin_data};

   // instruction register, written with select high; ignored while busy
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         instr_code <= lcd_cmd_pkg::RESET_BYTE;
      end else if (strobe_fall && pin_rs && !pin_rw && !busy_flag) begin
         instr_code <= pin_data; // see RL1
      end
   end

   // ****************************************
   // bus read drive
   // ****************************************
   // select high returns busy alone; other bits read as zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_out <= lcd_cmd_pkg::RESET_BYTE;
         bus_oe <= 1'b0;
      end else begin
         bus_oe <= pin_level[10] && pin_rw;
         if (pin_rs) begin
            bus_out <= lcd_cmd_pkg::RESET_BYTE;
            bus_out[lcd_cmd_pkg::BUSY_BIT] <= busy_flag; // see RL14
         end else begin
            bus_out <= out_latch; // latch shown before the reload, see RL11
         end
      end
   end

   // ****************************************
   // queue between host and engine
   // ****************************************
   cmd_fifo #(
      .WIDTH($bits(lcd_cmd_pkg::cmd_entry_s)),
      .DEPTH(lcd_cmd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_entry),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_entry)
   );

   // engine drains only while idle, so the queue backs up otherwise
   assign pop_ready = (state == lcd_cmd_pkg::EX_IDLE);

   // ****************************************
   // display memory
   // ****************************************
   // every access goes to the cursor address
   display_ram u_ram (
      .sys_clk(sys_clk),
      .addr(cursor_address), // see RL18
      .wr_en(ram_wr_en),
      .wr_data(ram_wr_data),
      .rd_data(ram_rd_data)
   );

   // write strobe for plain writes and read-modify-write
   always_comb begin
      ram_wr_en = 1'b0;
      ram_wr_data = cur.data;
      if (state == lcd_cmd_pkg::EX_START && cur.code == lcd_cmd_pkg::CODE_RAM_WR) begin
         ram_wr_en = 1'b1; // see RL10
      end else if (state == lcd_cmd_pkg::EX_MODIFY) begin
         if (cur.code == lcd_cmd_pkg::CODE_BIT_CLR) begin
            ram_wr_en = 1'b1;
            ram_wr_data = ram_rd_data & ~bit_mask(cur.data); // see RL13
         end else if (cur.code == lcd_cmd_pkg::CODE_BIT_SET) begin
            ram_wr_en = 1'b1;
            ram_wr_data = ram_rd_data | bit_mask(cur.data); // see RL13
         end
      end
   end

   // ****************************************
   // execution state machine
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         lcd_cmd_pkg::EX_IDLE: begin
            if (pop_valid) begin
               next_state = lcd_cmd_pkg::EX_START;
            end
         end
         lcd_cmd_pkg::EX_START: begin
            next_state = lcd_cmd_pkg::EX_MODIFY;
         end
         lcd_cmd_pkg::EX_MODIFY: begin
            next_state = lcd_cmd_pkg::EX_WAIT;
         end
         lcd_cmd_pkg::EX_WAIT: begin
            if (wait_cnt == '0) begin
               next_state = lcd_cmd_pkg::EX_IDLE;
            end
         end
         default: begin
            next_state = lcd_cmd_pkg::EX_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= lcd_cmd_pkg::EX_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // current operation and its wait count
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
         wait_cnt <= '0;
      end else if (state == lcd_cmd_pkg::EX_IDLE && pop_valid) begin
         cur <= pop_entry;
         wait_cnt <= exec_wait(pop_entry.code); // see RL17
      end else if (state == lcd_cmd_pkg::EX_WAIT && wait_cnt != '0) begin
         wait_cnt <= wait_cnt - 1'b1;
      end
   end

   // ****************************************
   // busy flag
   // ****************************************
   // set on the accepting edge, dropped when the wait expires;
   // instruction writes never touch it
   always_comb begin
      next_busy = busy_flag;
      if (data_accept) begin
         next_busy = 1'b1; // see RL15
      end else if (state == lcd_cmd_pkg::EX_WAIT && wait_cnt == '0 && !pop_valid) begin
         next_busy = 1'b0; // see RL15
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_flag <= 1'b0;
      end else begin
         busy_flag <= next_busy;
      end
   end

   // ****************************************
   // setting registers
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         horizontal_count <= '0;
         time_division_count <= '0;
         cursor_row <= '0;
         start_low <= lcd_cmd_pkg::RESET_BYTE;
         start_high <= lcd_cmd_pkg::RESET_BYTE;
      end else if (state == lcd_cmd_pkg::EX_START) begin
         case (cur.code)
            lcd_cmd_pkg::CODE_HCOUNT: begin
               horizontal_count <= cur.data[lcd_cmd_pkg::COUNT_MSB:0]; // see RL2
            end
            lcd_cmd_pkg::CODE_DUTY: begin
               time_division_count <= cur.data[lcd_cmd_pkg::COUNT_MSB:0]; // see RL3
            end
            lcd_cmd_pkg::CODE_CROW: begin
               cursor_row <= cur.data[lcd_cmd_pkg::ROW_MSB:0]; // see RL4
            end
            lcd_cmd_pkg::CODE_START_LO: begin
               start_low <= cur.data; // see RL6
            end
            lcd_cmd_pkg::CODE_START_HI: begin
               start_high <= cur.data; // see RL6
            end
            default: begin
               start_low <= start_low;
            end
         endcase
      end
   end

   // start address as seen by the scan logic
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         display_start <= lcd_cmd_pkg::RESET_ADDR;
      end else if (graphic_mode) begin
         display_start <= {start_high, start_low}; // see RL6
      end else begin
         display_start <= {4'h0, start_high[lcd_cmd_pkg::START_HI_KEEP_MSB:0], start_low}; // see RL7
      end
   end

   // cursor bar spans the full pitch, even over a glyph
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cursor_length <= lcd_cmd_pkg::RESET_PITCH;
      end else begin
         cursor_length <= char_pitch; // see RL5
      end
   end

   // ****************************************
   // cursor address counter
   // ****************************************
   // the low load carries upward on a 1 to 0 of its msb, which is
   // why the host must follow with the high byte
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cursor_address <= lcd_cmd_pkg::RESET_ADDR;
      end else if (state == lcd_cmd_pkg::EX_START) begin
         case (cur.code)
            lcd_cmd_pkg::CODE_CUR_LO: begin
               cursor_address[7:0] <= cur.data; // see RL8
               if (cursor_address[7] && !cur.data[7]) begin
                  cursor_address[15:8] <= cursor_address[15:8] + 8'h01; // see RL8
               end
            end
            lcd_cmd_pkg::CODE_CUR_HI: begin
               cursor_address[15:8] <= cur.data; // see RL9
            end
            lcd_cmd_pkg::CODE_RAM_WR: begin
               cursor_address <= cursor_next(cursor_address); // see RL10
            end
            default: begin
               cursor_address <= cursor_address;
            end
         endcase
      end else if (state == lcd_cmd_pkg::EX_MODIFY) begin
         // read data is back now, so reads and bit ops advance here
         if (cur.code == lcd_cmd_pkg::CODE_RAM_RD || cur.code == lcd_cmd_pkg::CODE_BIT_CLR
             || cur.code == lcd_cmd_pkg::CODE_BIT_SET) begin
            cursor_address <= cursor_next(cursor_address); // see RL11
         end
      end
   end

   // ****************************************
   // data output latch
   // ****************************************
   // reloaded after the host has already taken the old value, so the
   // first read after a cursor load is stale
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_latch <= lcd_cmd_pkg::RESET_BYTE;
      end else if (state == lcd_cmd_pkg::EX_MODIFY && cur.code == lcd_cmd_pkg::CODE_RAM_RD) begin
         out_latch <= ram_rd_data; // see RL11, RL12
      end
   end
endmodule : lcd_command_port

/* verification/lcd_port_chk.sv */
`timescale 1ns/1ps
// ****************************************
// port checker of the command port
// ****************************************
module lcd_port_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // host pins
   input wire logic strobe_pin,
   input wire logic rw_pin,
   input wire logic reg_select,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   // mode inputs and settings
   input wire logic graphic_mode,
   input wire logic [3:0] char_pitch,
   input wire logic [6:0] horizontal_count,
   input wire logic [3:0] cursor_row,
   input wire logic [15:0] display_start,
   input wire logic [15:0] cursor_address,
   input wire logic [3:0] cursor_length,
   input wire logic busy_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // length of the current busy run; bit ops need the widest count
   logic [10:0] busy_cnt;
   // counts while busy, clears when idle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt <= 11'h000;
      end else begin
         busy_cnt <= busy_flag ? busy_cnt + 11'h001 : 11'h000;
      end
   end
   a_busy_bounded: assert property (busy_cnt <= 11'h384)
      else $error("busy ran too long");
   a_busy_holds: assert property ($rose(busy_flag) |-> busy_flag [*8])
      else $error("busy fell early");
   a_busy_cause: assert property ($rose(busy_flag) |-> !reg_select && !strobe_pin)
      else $error("busy rose without a data access");
   a_oe_cause: assert property ($rose(bus_oe) |-> $past(strobe_pin, 2) && $past(rw_pin, 2))
      else $error("bus driven without a read");
   a_oe_release: assert property ($fell(strobe_pin) |-> ##[1:8] !bus_oe)
      else $error("bus still driven after strobe");
   a_busy_readout: assert property (bus_oe && $past(bus_oe) && reg_select && $stable(busy_flag)
      |-> bus_out == {busy_flag, 7'h00})
      else $error("busy read value wrong");
   a_quiet_idle: assert property (($changed(cursor_address) || $changed(horizontal_count) || $changed(cursor_row))
      |-> busy_flag)
      else $error("setting changed while idle");
   a_start_mask: assert property (!graphic_mode && !$past(graphic_mode) |-> display_start[15:12] == 4'h0)
      else $error("start address not masked");
   a_length_copy: assert property ($past(arst_n) && $stable(char_pitch) |-> cursor_length == char_pitch)
      else $error("cursor length differs from pitch");
   c_busy_end: cover property ($fell(busy_flag));
   c_busy_read: cover property (bus_oe && reg_select && busy_flag);
   c_char_mode: cover property (!graphic_mode && display_start != 16'h0000);
endmodule : lcd_port_chk

bind lcd_command_port lcd_port_chk u_chk (.sys_clk, .arst_n, .strobe_pin, .rw_pin, .reg_select, .bus_out, .bus_oe,
   .graphic_mode, .char_pitch, .horizontal_count, .cursor_row, .display_start, .cursor_address, .cursor_length,
   .busy_flag);

/* verification/host_mcu_model.sv */
`timescale 1ns/1ps
// ****************************************
// host microcontroller model
// ****************************************
module host_mcu_model (
   // clock
   input wire logic sys_clk,
   // bus pins toward the controller
   output logic strobe_pin,
   output logic rw_pin,
   output logic reg_select,
   output logic [7:0] bus_in,
   input wire logic [7:0] bus_out
);
   // idle pins
   initial begin
      strobe_pin = 1'b0;
      rw_pin = 1'b1;
      reg_select = 1'b1;
      bus_in = 8'h00;
   end
   // one bus cycle; pins settle before strobe and hold well past its fall
   task automatic access(input logic rs, input logic rd, input logic [7:0] wdata, output logic [7:0] rdata);
      @(posedge sys_clk);
      reg_select <= rs;
      rw_pin <= rd;
      bus_in <= wdata;
      repeat (2) @(posedge sys_clk);
      strobe_pin <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rdata = bus_out;
      strobe_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      bus_in <= ~wdata; // released lines must not echo the last byte
   endtask : access
   // poll busy until clear, bounded so a stuck flag cannot hang us
   task automatic poll(output int tries);
      logic [7:0] st;
      tries = 0;
      do begin
         access(1'b1, 1'b1, 8'h00, st);
         tries++;
      end while (st[7] !== 1'b0 && tries < 60);
   endtask : poll
endmodule : host_mcu_model

/* verification/graphic_lcd_command_port_tb_top.sv */
`timescale 1ns/1ps
`define chk(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
// ****************************************
// command port testbench
// ****************************************
module graphic_lcd_command_port_tb_top;
   // clock, reset and mode inputs
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic graphic_mode = 1'b1;
   logic [3:0] char_pitch = 4'h6;
   // host pins and device outputs
   logic strobe_pin, rw_pin, reg_select, bus_oe, busy_flag;
   logic [7:0] bus_in, bus_out;
   logic [6:0] horizontal_count, time_division_count;
   logic [3:0] cursor_row, cursor_length;
   logic [15:0] display_start, cursor_address;
   // tallies
   int fails = 0;
   int checks_done = 0;
   // one setting case: instruction, data byte, expected setting
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] data;
      logic [15:0] want;
   } row_s;
   row_s rows [9] = '{'{8'h02, 8'h7f, 16'h007f}, '{8'h03, 8'h40, 16'h0040}, '{8'h04, 8'h0f, 16'h000f},
      '{8'h08, 8'h34, 16'h0034}, '{8'h09, 8'ha5, 16'ha534}, '{8'h0a, 8'h80, 16'h0080},
      '{8'h0b, 8'h12, 16'h1280}, '{8'h0a, 8'h10, 16'h1310}, '{8'h0b, 8'h12, 16'h1210}};
   // first read is the dummy, its value is not compared
   logic [7:0] rd_want [3] = '{8'h00, 8'h5b, 8'h25};
   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;
   lcd_command_port uut (.sys_clk, .arst_n, .strobe_pin, .rw_pin, .reg_select, .bus_in, .bus_out, .bus_oe,
      .graphic_mode, .char_pitch, .horizontal_count, .time_division_count, .cursor_row, .display_start,
      .cursor_address, .cursor_length, .busy_flag);
   host_mcu_model host (.sys_clk, .strobe_pin, .rw_pin, .reg_select, .bus_in, .bus_out);
   // setting that a code loads, widened for one compare
   function automatic logic [15:0] setting(input logic [7:0] code);
      case (code)
         8'h02: setting = {9'h000, horizontal_count};
         8'h03: setting = {9'h000, time_division_count};
         8'h04: setting = {12'h000, cursor_row};
         8'h08, 8'h09: setting = display_start;
         default: setting = cursor_address;
      endcase
   endfunction : setting
   // instruction then data, busy span measured, then polled clear
   task automatic exec(input logic [7:0] code, input logic [7:0] data, input int limit, input bit extra);
      logic [7:0] st;
      int n;
      int tries;
      host.access(1'b1, 1'b0, code, st);
      host.access(1'b0, 1'b0, data, st);
      if (extra) begin
         host.access(1'b0, 1'b0, 8'hff, st);
         host.access(1'b1, 1'b1, 8'h00, st);
         `chk("busy_bit", 1'b1, st[7])
      end
      n = 0;
      while (busy_flag === 1'b1 && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
      `chk("busy_span", 1'b1, n > 0 && n + 5 <= limit)
      host.poll(tries);
      `chk("poll_done", 1'b1, tries < 60)
   endtask : exec
   // ****************************************
   // verdict and watchdog
   // ****************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   // whole run needs some 5k cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [7:0] d;
      int t;
      repeat (12) @(posedge sys_clk);
      `chk("busy_rst", 1'b0, busy_flag)
      `chk("len_rst", 4'h8, cursor_length)
      arst_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
      `chk("len_pitch", 4'h6, cursor_length)
      foreach (rows[i]) begin
         exec(rows[i].code, rows[i].data, 100, 1'b0);
         `chk("setting", rows[i].want, setting(rows[i].code))
      end
      graphic_mode <= 1'b0;
      char_pitch <= 4'h7;
      repeat (3) @(posedge sys_clk);
      `chk("start_char", 16'h0534, display_start)
      `chk("len_pitch", 4'h7, cursor_length)
      exec(8'h0c, 8'h5a, 150, 1'b0);
      exec(8'h0c, 8'ha5, 150, 1'b1);
      `chk("cursor_wr", 16'h1212, cursor_address)
      exec(8'h0a, 8'h10, 100, 1'b0);
      exec(8'h0b, 8'h12, 100, 1'b0);
      exec(8'h0f, 8'h00, 900, 1'b0);
      exec(8'h0e, 8'h07, 900, 1'b0);
      exec(8'h0a, 8'h10, 100, 1'b0);
      exec(8'h0b, 8'h12, 100, 1'b0);
      host.access(1'b1, 1'b0, 8'h0d, d);
      foreach (rd_want[i]) begin
         host.access(1'b0, 1'b1, 8'h00, d);
         host.poll(t);
         if (i > 0) `chk("ram_rd", rd_want[i], d)
      end
      `chk("cursor_rd", 16'h1213, cursor_address)
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      `chk("cursor_rst", 16'h0000, cursor_address)
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      give_verdict();
   end
endmodule : graphic_lcd_command_port_tb_top
